// ---- hdl/iaoe_exec.sv ----
// execution of increment-skip, increment and or-literal
// assumes register file read data is combinational from addr
// and that the fetch path honours the discard pulse next cycle
`timescale 1ns/100ps
module iaoe_exec (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // instruction stream
  input  wire logic [13:0] instr_i,
  input  wire logic        instr_valid_i,
  // register file read port
  input  wire logic [7:0]  rf_rdata_i,
  output logic      [6:0]  rf_raddr_o,
  // register file write port
  output logic             rf_we_o,
  output logic      [6:0]  rf_waddr_o,
  output logic      [7:0]  rf_wdata_o,
  // architectural state
  output logic      [7:0]  acc_o,
  output logic             zero_o,
  // pipeline control
  output logic             discard_o,
  output logic             nop_exec_o
);
  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] acc;
    logic       zero;
    logic       we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic       skip;    // next fetched word becomes a nop
    logic       nop;
    logic [6:0] raddr;
  } iaoe_state_t;

  iaoe_state_t s_reg;
  iaoe_state_t s_next;
  iaoe_dec_if  dif ();
  logic [7:0]  inc_res;

  ////////////////////////////////////////////////////////////////////
  iaoe_decoder u_dec (
    .instr_i (instr_i),
    .dec     (dif)
  );

  // 8-bit wrap on increment
  assign inc_res = rf_rdata_i + 8'h01;

  ////////////////////////////////////////////////////////////////////
  // next state: the read address is fed from the decoded word
  always_comb begin
    s_next       = s_reg;
    s_next.we    = 1'b0;
    // pending skip waits for a valid word
    // an idle cycle must not eat the skip, or the next word would run
    s_next.skip  = s_reg.skip && !instr_valid_i;
    s_next.nop   = 1'b0;
    s_next.raddr = dif.addr;
    if (instr_valid_i && s_reg.skip) begin
      s_next.nop = 1'b1;
    end else if (instr_valid_i) begin
      case (dif.op)
        iaoe_pkg::IAOE_OP_INC_SKIP: begin
          if (dif.dest) begin
            s_next.we    = 1'b1;
            s_next.waddr = dif.addr;
            s_next.wdata = inc_res;
          end else begin
            s_next.acc = inc_res;
          end
          s_next.skip = (inc_res == 8'h00);
          s_next.zero = s_reg.zero;
        end
        iaoe_pkg::IAOE_OP_INC: begin
          if (dif.dest) begin
            s_next.we    = 1'b1;
            s_next.waddr = dif.addr;
            s_next.wdata = inc_res;
          end else begin
            s_next.acc = inc_res;
          end
          s_next.zero = (inc_res == 8'h00);
        end
        iaoe_pkg::IAOE_OP_OR_LIT: begin
          s_next.acc  = s_reg.acc | dif.lit;
          s_next.zero = ((s_reg.acc | dif.lit) == 8'h00);
        end
        default: begin
          s_next.skip = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg      <= '0;
      s_reg.acc  <= iaoe_pkg::ACC_RST;
      s_reg.zero <= iaoe_pkg::ZERO_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign rf_raddr_o = s_reg.raddr;
  assign rf_we_o    = s_reg.we;
  assign rf_waddr_o = s_reg.waddr;
  assign rf_wdata_o = s_reg.wdata;
  assign acc_o      = s_reg.acc;
  assign zero_o     = s_reg.zero;
  assign discard_o  = s_reg.skip;
  assign nop_exec_o = s_reg.nop;
endmodule : iaoe_exec

// ---- inc/iaoe_pkg.sv ----
// package for the increment / or-literal execution slice of an 8-bit core
// assumes a 14-bit instruction word and an 8-bit data path
// Summary of operation
// - 001111 d f: increment, skip on zero, flags kept
// - zero result discards fetched next instruction
// - d=0 writes accumulator, d=1 writes register
// - 001010 d f: increment, zero flag only
// - 111000 k: or literal into accumulator
package iaoe_pkg;
  localparam int        IW_W        = 14;
  localparam int        DW          = 8;
  localparam int        AW          = 7;
  localparam int        OP_HI       = 13;
  localparam int        OP_LO       = 8;
  localparam int        DEST_BIT    = 7;
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] OP_INC      = 6'h0a;
  localparam logic [5:0] OP_OR_LIT   = 6'h38;
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic       ZERO_RST    = 1'b0;

  typedef enum logic [1:0] {
    IAOE_OP_NONE,
    IAOE_OP_INC_SKIP,
    IAOE_OP_INC,
    IAOE_OP_OR_LIT
  } iaoe_op_t;
endpackage : iaoe_pkg

// ---- inc/iaoe_dec_if.sv ----
// decoded instruction fields passed from decoder to execute stage
// assumes one decode per clock cycle
`timescale 1ns/100ps
interface iaoe_dec_if;
  iaoe_pkg::iaoe_op_t op;
  logic               dest;
  logic [6:0]         addr;
  logic [7:0]         lit;
  modport dec (output op, output dest, output addr, output lit);
  modport exe (input op, input dest, input addr, input lit);
endinterface : iaoe_dec_if

// ---- hdl/iaoe_decoder.sv ----
// combinational decoder for the three handled opcodes
// assumes the instruction word is stable for the whole cycle
`timescale 1ns/100ps
module iaoe_decoder (
  // instruction in
  input  wire logic [13:0] instr_i,
  // decoded fields out
  iaoe_dec_if.dec          dec
);
  // opcode match on the top six bits
  always_comb begin
    dec.dest = instr_i[iaoe_pkg::DEST_BIT];
    dec.addr = instr_i[iaoe_pkg::AW-1:0];
    dec.lit  = instr_i[iaoe_pkg::DW-1:0];
    case (instr_i[iaoe_pkg::OP_HI:iaoe_pkg::OP_LO])
      iaoe_pkg::OP_INC_SKIP: dec.op = iaoe_pkg::IAOE_OP_INC_SKIP;
      iaoe_pkg::OP_INC:      dec.op = iaoe_pkg::IAOE_OP_INC;
      iaoe_pkg::OP_OR_LIT:   dec.op = iaoe_pkg::IAOE_OP_OR_LIT;
      default:               dec.op = iaoe_pkg::IAOE_OP_NONE;
    endcase
  end
endmodule : iaoe_decoder

// ---- test/iaoe_exec_monitor.sv ----
// checker bound to iaoe_exec
// assumes one clock, async low reset
`timescale 1ns/100ps
module iaoe_exec_monitor (
  // inputs
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [13:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic [7:0]  rf_rdata_i,
  // outputs
  input wire logic [6:0]  rf_raddr_o,
  input wire logic        rf_we_o,
  input wire logic [7:0]  rf_wdata_o,
  input wire logic [7:0]  acc_o,
  input wire logic        zero_o,
  input wire logic        discard_o,
  input wire logic        nop_exec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // a word pending discard is never executed
  sequence s_go; instr_valid_i && !discard_o; endsequence
  sequence s_isz; s_go ##0 instr_i[13:8] == 6'h0f; endsequence
  sequence s_inc; s_go ##0 instr_i[13:8] == 6'h0a; endsequence
  a_skip_zero: assert property (s_isz |=> $stable(zero_o)) else $error("z");
  a_skip_take: assert property (s_isz |=> discard_o == ($past(rf_rdata_i) == 8'hff))
    else $error("skip");
  a_nop_slot: assert property (discard_o && instr_valid_i |=> nop_exec_o && !rf_we_o)
    else $error("nop");
  a_skip_hold: assert property (discard_o && !instr_valid_i |=> discard_o)
    else $error("skip lost");
  a_dest_reg: assert property ((s_isz or s_inc) ##0 instr_i[7] |=> rf_we_o &&
    rf_wdata_o == $past(rf_rdata_i) + 8'h01) else $error("dest");
  a_inc_zero: assert property (s_inc |=> zero_o == ($past(rf_rdata_i) == 8'hff))
    else $error("inc z");
  a_or_acc: assert property (s_go ##0 instr_i[13:8] == 6'h38 |=> acc_o ==
    ($past(acc_o) | $past(instr_i[7:0]))) else $error("or");
  a_raddr_copy: assert property (1'b1 |=> rf_raddr_o == $past(instr_i[6:0]))
    else $error("raddr");
endmodule : iaoe_exec_monitor
bind iaoe_exec iaoe_exec_monitor iaoe_exec_monitor_inst (.clk_i, .nrst_i, .instr_i,
  .instr_valid_i, .rf_rdata_i, .rf_raddr_o, .rf_we_o, .rf_wdata_o, .acc_o, .zero_o,
  .discard_o, .nop_exec_o);

// ---- test/iaoe_exec_bench.sv ----
// bench: random words of the three ops and an unknown opcode, queued checks
// assumes the bench plays the register file
`timescale 1ns/100ps
module iaoe_exec_bench;
  logic clk_i = 0, nrst_i = 0, instr_valid_i = 0, z = 0, sk = 0, seen = 0, n, w, i;
  logic [13:0] instr_i = 0;
  logic [7:0] rf_rdata_i = 0, acc = 0, rd;
  wire [7:0] rf_wdata_o, acc_o;
  wire [6:0] rf_waddr_o;
  wire rf_we_o, zero_o, discard_o, nop_exec_o;
  logic [26:0] q[$];
  logic [31:0] r = 51;
  int miscompares = 0, tests_run = 0;
  iaoe_exec iaoe_exec_inst (.clk_i, .nrst_i, .instr_i, .instr_valid_i, .rf_rdata_i,
    .rf_raddr_o(), .rf_we_o, .rf_waddr_o, .rf_wdata_o, .acc_o, .zero_o, .discard_o, .nop_exec_o);
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [26:0] g, x);
    tests_run++;
    if (g !== x) miscompares++;
    if (g !== x) $display("ERROR %0t got %h exp %h", $time, g, x);
  endtask : chk
  task automatic finish_test;
    $display("%0d checks %0d bad", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    #15us miscompares++;
    finish_test;
  end
  // results land on the taking edge and are checked at the next falling edge
  always @(posedge clk_i) seen <= instr_valid_i;
  always @(negedge clk_i) if (seen) chk({acc_o, zero_o, rf_we_o, rf_we_o ? {rf_waddr_o,
    rf_wdata_o} : 15'h0000, discard_o, nop_exec_o}, q.pop_front());
  // ops mixed with idle cycles and an unknown opcode
  initial begin
    repeat (6) @(posedge clk_i);
    #1 nrst_i = 1;
    repeat (300) begin
      @(posedge clk_i);
      r = xs(r);
      #1 instr_valid_i = r[31:30] != 2'h0;
      instr_i = {r[9] ? {r[8], 5'h18} : {3'h1, r[8], 1'h1, r[8]}, r[7:0]};
      rf_rdata_i = r[12] ? 8'hff : r[20:13];
      if (!instr_valid_i) continue;
      {n, rd, i} = {sk, rf_rdata_i + 8'h01, !sk && !r[9]};
      w = i && r[7];
      sk = i && r[8] && rd == 8'h00;
      if (i && !r[8]) z = rd == 8'h00;
      if (i && !w) acc = rd;
      if (!n && r[9:8] == 2'h3) {acc, z} = {acc | r[7:0], (acc | r[7:0]) == 8'h00};
      q.push_back({acc, z, w, w ? {r[6:0], rd} : 15'h0000, sk, n});
    end
    repeat (2) @(posedge clk_i);
    finish_test;
  end
endmodule : iaoe_exec_bench
